//--- hdl/line_interface_config_select.sv
// Operating mode decode, shared-pin function select, monitoring point decode
// and per-channel loss-of-signal flags for an octal line interface.
// Assumes straps and hardware-mode pins are asynchronous board levels.
// How it works
// [R1] Hardware unipolar, line code select low: zero-substitution code (HDB3 or B8ZS).
// [R2] Hardware unipolar, line code select high: AMI transparent coding.
// [R3] Host mode takes line code from a software bit, pin ignored.
// [R4] Host mode: shared pin chooses bus style, high one variant, low other.
// [R5] Host drives active-low chip select low for each whole access.
// [R6] Hardware: attenuator position low transmit, high receive, floating disabled.
// [R7] Mode strap: low hardware, high parallel host, mid serial host.
// [R8] Hardware mode disables parallel port, uses dedicated configuration pins.
// [R9] Parallel mode uses parallel port; serial mode uses four-wire serial port.
// [R10] Parallel mode bus multiplex select: low non-multiplexed, high multiplexed.
// [R11] Board ties bus multiplex select low in hardware mode.
// [R12] Board grounds monitor select msb in hardware mode.
// [R13] Host mode: monitor pins become address inputs, monitoring from register; the code drives the address to zero in multiplexed parallel mode.
// [R14] Channel code zero: no monitoring, plain octal transceiver.
// [R15] Direction zero, code n nonzero: receiver n to monitoring point.
// [R16] Direction one, code n nonzero: transmitter n to monitoring point.
// [R17] Transmitter monitoring of an analog-loopback channel is unsupported.
// [R18] Loss flag high after silence for the interval, low with signal.
// [R19] Loss flag clears only after enough marks within the window.
// [R20] Three-level straps become stable two-bit codes driving the pin mux.
`timescale 1ns/1ps
module line_interface_config_select #(
   parameter int LOSS_CYCLES  = cfg_select_pkg::LOSS_CYCLES,
   parameter int CLEAR_CYCLES = cfg_select_pkg::CLEAR_CYCLES,
   parameter int CLEAR_MARKS  = cfg_select_pkg::CLEAR_MARKS
) (
   input  wire logic       i_clk,
   input  wire logic       i_sys_rst,
   input  wire logic       i_mode_probe_up,
   input  wire logic       i_mode_probe_dn,
   input  wire logic       i_atten_probe_up,
   input  wire logic       i_atten_probe_dn,
   input  wire logic       i_code_bus_pin,
   input  wire logic       i_bus_multiplex_select,
   input  wire logic [4:0] i_monitor_pins,
   input  wire logic [7:0] i_unipolar_bipolar_select,
   input  wire logic       i_sw_line_code_select,
   input  wire logic       i_sw_monitor_direction_select,
   input  wire logic [2:0] i_sw_monitor_channel_code,
   input  wire logic [7:0] i_analog_loopback,
   input  wire logic [7:0] i_rx_mark,
   output logic [1:0]      o_op_mode,
   output logic [7:0]      o_line_code_ami,
   output logic            o_host_bus_style_select,
   output logic [1:0]      o_jitter_atten_position,
   output logic            o_parallel_port_en,
   output logic            o_serial_port_en,
   output logic            o_bus_multiplexed,
   output logic [4:0]      o_host_address,
   output logic            o_monitor_en,
   output logic            o_monitor_direction_select,
   output logic [2:0]      o_monitor_channel_code,
   output logic            o_monitor_unsupported,
   output logic [7:0]      o_signal_loss_flag
);
   cfg_select_pkg::level_t mode_lvl;
   cfg_select_pkg::level_t atten_lvl;

   strap_level_sync u_mode_strap (
      .i_clk      (i_clk),
      .i_sys_rst  (i_sys_rst),
      .i_probe_up (i_mode_probe_up),
      .i_probe_dn (i_mode_probe_dn),
      .o_level    (mode_lvl)
   );

   strap_level_sync u_atten_strap (
      .i_clk      (i_clk),
      .i_sys_rst  (i_sys_rst),
      .i_probe_up (i_atten_probe_up),
      .i_probe_dn (i_atten_probe_dn),
      .o_level    (atten_lvl)
   );

   // Digital pins pass three flops; a change counts once stages two and three agree.
   localparam int PW = 1 + 1 + 5 + 8;
   logic [PW-1:0] pin_s1_ff;
   logic [PW-1:0] pin_s2_ff;
   logic [PW-1:0] pin_s3_ff;
   logic [PW-1:0] pin_ff;
   wire  [PW-1:0] pin_raw = {i_code_bus_pin, i_bus_multiplex_select, i_monitor_pins,
                             i_unipolar_bipolar_select};
   wire  [PW-1:0] pin_agree = ~(pin_s2_ff ^ pin_s3_ff);
   wire  [PW-1:0] nxt_pin = (pin_s3_ff & pin_agree) | (pin_ff & ~pin_agree);

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pin_s1_ff <= '0;
         pin_s2_ff <= '0;
         pin_s3_ff <= '0;
         pin_ff    <= '0;
      end else begin
         pin_s1_ff <= pin_raw;
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
         pin_ff    <= nxt_pin;
      end
   end

   wire       code_bus_pin = pin_ff[14];
   wire       mux_pin      = pin_ff[13];
   wire [4:0] mon_pins     = pin_ff[12:8];
   wire [7:0] uni_pins     = pin_ff[7:0];

   // Mode decode.
   function automatic cfg_select_pkg::op_mode_t mode_of(input cfg_select_pkg::level_t l);
      case (l)
         cfg_select_pkg::LVL_LOW:  mode_of = cfg_select_pkg::MODE_HW;
         cfg_select_pkg::LVL_HIGH: mode_of = cfg_select_pkg::MODE_PARALLEL;
         cfg_select_pkg::LVL_MID:  mode_of = cfg_select_pkg::MODE_SERIAL;
         default:                  mode_of = cfg_select_pkg::MODE_HW;
      endcase
   endfunction

   wire cfg_select_pkg::op_mode_t mode = mode_of(mode_lvl); // see [R7]
   wire hw_mode   = (mode == cfg_select_pkg::MODE_HW);
   wire par_mode  = (mode == cfg_select_pkg::MODE_PARALLEL);
   wire ser_mode  = (mode == cfg_select_pkg::MODE_SERIAL);

   // Line code: the hardware pin applies only to unipolar channels; host uses the bit.
   wire [7:0] nxt_line_code;
   genvar g;
   generate
      for (g = 0; g < cfg_select_pkg::CHANNELS; g++) begin : g_code
         assign nxt_line_code[g] = hw_mode ? (uni_pins[g] ? code_bus_pin  // see [R1] [R2]
                                                         : cfg_select_pkg::LINE_CODE_ZS)
                                           : i_sw_line_code_select;       // see [R3]
      end
   endgenerate

   // Host bus style only meaningful in host modes; held low in hardware mode.
   wire nxt_bus_style = !hw_mode && code_bus_pin; // see [R4]

   // A floating position pin disables the attenuator; host modes leave it off.
   wire [1:0] nxt_atten = !hw_mode ? cfg_select_pkg::ATTEN_OFF :
                          (atten_lvl == cfg_select_pkg::LVL_LOW)  ? cfg_select_pkg::ATTEN_TX :
                          (atten_lvl == cfg_select_pkg::LVL_HIGH) ? cfg_select_pkg::ATTEN_RX :
                          cfg_select_pkg::ATTEN_OFF; // see [R6]

   wire nxt_par_en = par_mode;  // see [R8] [R9]
   wire nxt_ser_en = ser_mode;  // see [R9]
   // The multiplex input is ignored outside parallel mode; the board ties it low in hardware mode.
   wire nxt_muxed  = par_mode && mux_pin; // see [R10] [R11]

   // Monitor pins become address inputs in non-multiplexed host operation.
   wire       pins_are_addr = !hw_mode && !nxt_muxed;
   wire [4:0] nxt_addr = pins_are_addr ? mon_pins : 5'h00; // see [R13]

   // Monitoring source: pins in hardware mode (msb grounded by the board), else software.
   wire       mon_dir  = hw_mode ? mon_pins[3] : i_sw_monitor_direction_select; // see [R12] [R13]
   wire [2:0] mon_code = hw_mode ? mon_pins[2:0] : i_sw_monitor_channel_code;
   wire       nxt_mon_en = (mon_code != 3'h0); // see [R14]
   wire [2:0] nxt_mon_code = mon_code;          // see [R15] [R16]
   wire       nxt_unsup = nxt_mon_en && mon_dir && i_analog_loopback[mon_code]; // see [R17]

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_op_mode                  <= cfg_select_pkg::MODE_HW;
         o_line_code_ami            <= 8'h00;
         o_host_bus_style_select    <= 1'h0;
         o_jitter_atten_position    <= cfg_select_pkg::ATTEN_OFF;
         o_parallel_port_en         <= 1'h0;
         o_serial_port_en           <= 1'h0;
         o_bus_multiplexed          <= 1'h0;
         o_host_address             <= 5'h00;
         o_monitor_en               <= 1'h0;
         o_monitor_direction_select <= 1'h0;
         o_monitor_channel_code     <= 3'h0;
         o_monitor_unsupported      <= 1'h0;
      end else begin
         o_op_mode                  <= mode;
         o_line_code_ami            <= nxt_line_code;
         o_host_bus_style_select    <= nxt_bus_style;
         o_jitter_atten_position    <= nxt_atten;
         o_parallel_port_en         <= nxt_par_en;
         o_serial_port_en           <= nxt_ser_en;
         o_bus_multiplexed          <= nxt_muxed;
         o_host_address             <= nxt_addr;
         o_monitor_en               <= nxt_mon_en;
         o_monitor_direction_select <= nxt_mon_en && mon_dir;
         o_monitor_channel_code     <= nxt_mon_code;
         o_monitor_unsupported      <= nxt_unsup;
      end
   end

   // Loss-of-signal detector per channel. Marks arrive already synchronised.
   // A window that runs out with too few marks starts afresh, so marks that straddle
   // two windows never add up; recovery can therefore take up to two windows.
   localparam int TW = cfg_select_pkg::TIMER_W;
   localparam int MW = cfg_select_pkg::MARK_W;
   localparam logic [TW-1:0] LOSS_LIM  = TW'(LOSS_CYCLES - 1);
   localparam logic [TW-1:0] CLEAR_LIM = TW'(CLEAR_CYCLES - 1);
   localparam logic [MW-1:0] MARK_LIM  = MW'(CLEAR_MARKS);

   generate
      for (g = 0; g < cfg_select_pkg::CHANNELS; g++) begin : g_loss
         logic [TW-1:0] quiet_ff;
         logic [TW-1:0] win_ff;
         logic [MW-1:0] marks_ff;
         logic          loss_ff;
         wire quiet_done = (quiet_ff == LOSS_LIM);
         wire win_done   = (win_ff == CLEAR_LIM);
         wire marks_ok   = (marks_ff + MW'(i_rx_mark[g])) >= MARK_LIM;
         wire [TW-1:0] nxt_quiet = i_rx_mark[g] ? '0 :
                                   quiet_done ? quiet_ff : quiet_ff + 1'b1;
         wire [TW-1:0] nxt_win   = (!loss_ff || win_done || marks_ok) ? '0 : win_ff + 1'b1;
         wire [MW-1:0] nxt_marks = (!loss_ff || win_done || marks_ok) ? '0 :
                                   marks_ff + MW'(i_rx_mark[g]);
         wire nxt_loss = loss_ff ? !marks_ok                      // see [R19]
                                 : (quiet_done && !i_rx_mark[g]); // see [R18]

         always_ff @(posedge i_clk) begin
            if (i_sys_rst) begin
               quiet_ff <= '0;
               win_ff   <= '0;
               marks_ff <= '0;
               loss_ff  <= 1'b0;
            end else begin
               quiet_ff <= nxt_quiet;
               win_ff   <= nxt_win;
               marks_ff <= nxt_marks;
               loss_ff  <= nxt_loss;
            end
         end
         assign o_signal_loss_flag[g] = loss_ff;

         loss_quiet_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R18]
            !loss_ff && quiet_done && !i_rx_mark[g] |=> loss_ff)
            else $error("loss flag did not rise after silence");
         loss_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R19]
            loss_ff && !marks_ok |=> loss_ff)
            else $error("loss flag cleared without enough marks");
      end
   endgenerate

   // Assertions on the registered configuration outputs.
   mode_decode_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R7]
      mode_lvl == cfg_select_pkg::LVL_MID |=> o_op_mode == cfg_select_pkg::MODE_SERIAL)
      else $error("mid strap did not select serial mode");
   hw_port_off_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R8]
      hw_mode |=> !o_parallel_port_en && !o_serial_port_en)
      else $error("host port enabled in hardware mode");
   code_ami_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R2]
      hw_mode && uni_pins[0] && code_bus_pin |=> o_line_code_ami[0])
      else $error("AMI not selected");
   code_zs_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R1]
      hw_mode && uni_pins[0] && !code_bus_pin |=> !o_line_code_ami[0])
      else $error("zero-substitution code not selected");
   sw_code_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R3]
      !hw_mode |=> o_line_code_ami[0] == $past(i_sw_line_code_select))
      else $error("host line code not from software bit");
   bus_style_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R4]
      !hw_mode |=> o_host_bus_style_select == $past(code_bus_pin))
      else $error("bus style not from shared pin");
   atten_float_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R6]
      hw_mode && atten_lvl == cfg_select_pkg::LVL_MID
      |=> o_jitter_atten_position == cfg_select_pkg::ATTEN_OFF)
      else $error("floating position did not disable attenuator");
   mon_zero_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R14]
      mon_code == 3'h0 |=> !o_monitor_en && !o_monitor_direction_select)
      else $error("monitoring active with code zero");
   mon_route_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R15]
      mon_code != 3'h0 |=> o_monitor_en && o_monitor_channel_code == $past(mon_code))
      else $error("monitoring channel not routed");
   mux_sel_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R10]
      !par_mode |=> !o_bus_multiplexed)
      else $error("multiplexed outside parallel mode");

   mux_on_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R10]
      par_mode && mux_pin |=> o_bus_multiplexed)
      else $error("multiplexed bus not selected");
   bs_hw_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R4]
      hw_mode |=> !o_host_bus_style_select)
      else $error("bus style driven in hardware mode");
   serial_port_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R9]
      ser_mode |=> o_serial_port_en && !o_parallel_port_en)
      else $error("serial mode did not pick the serial port");
   addr_hw_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R13]
      hw_mode |=> o_host_address == 5'h00)
      else $error("address driven in hardware mode");
   sw_mon_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R13]
      !hw_mode |=> o_monitor_channel_code == $past(i_sw_monitor_channel_code))
      else $error("host monitoring not from software code");

   // Routing and attenuator placement checks.
   rx_route_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R15]
      mon_code != 3'h0 && !mon_dir |=> !o_monitor_direction_select)
      else $error("receiver monitoring shown as transmitter");
   tx_route_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R16]
      mon_code != 3'h0 && mon_dir |=> o_monitor_direction_select)
      else $error("transmitter monitoring not selected");
   unsup_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R17]
      mon_code != 3'h0 && mon_dir && i_analog_loopback[mon_code] |=> o_monitor_unsupported)
      else $error("loopback transmitter monitoring not flagged");
   atten_tx_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R6]
      hw_mode && atten_lvl == cfg_select_pkg::LVL_LOW
      |=> o_jitter_atten_position == cfg_select_pkg::ATTEN_TX)
      else $error("low position did not pick transmit path");
   atten_rx_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // see [R6]
      hw_mode && atten_lvl == cfg_select_pkg::LVL_HIGH
      |=> o_jitter_atten_position == cfg_select_pkg::ATTEN_RX)
      else $error("high position did not pick receive path");

   serial_c: cover property (@(posedge i_clk) o_serial_port_en);
   tx_mon_c: cover property (@(posedge i_clk) o_monitor_en && o_monitor_direction_select);
   loss_c:   cover property (@(posedge i_clk) o_signal_loss_flag[2] ##1 !o_signal_loss_flag[2]);
   rx_ja_c:  cover property (@(posedge i_clk) o_jitter_atten_position == cfg_select_pkg::ATTEN_RX);
   unsup_c:  cover property (@(posedge i_clk) o_monitor_unsupported);
endmodule // line_interface_config_select

//--- hdl/cfg_select_pkg.sv
// Constants for the line interface configuration and pin-function select.
// Assumes one 50 MHz clock and a synchronous active-high reset.
package cfg_select_pkg;
   // Two-bit code of a three-level strap.
   typedef enum logic [1:0] {
      LVL_LOW  = 2'h0,
      LVL_HIGH = 2'h1,
      LVL_MID  = 2'h3
   } level_t;

   // Operating modes, Gray coded.
   typedef enum logic [1:0] {
      MODE_HW       = 2'h0,
      MODE_PARALLEL = 2'h1,
      MODE_SERIAL   = 2'h3
   } op_mode_t;

   // Line code selections.
   localparam logic LINE_CODE_ZS  = 1'h0;
   localparam logic LINE_CODE_AMI = 1'h1;

   // Jitter attenuator placement.
   localparam logic [1:0] ATTEN_OFF = 2'h0;
   localparam logic [1:0] ATTEN_TX  = 2'h1;
   localparam logic [1:0] ATTEN_RX  = 2'h2;

   localparam int CHANNELS  = 8;
   localparam int CODE_W    = 3;

   // Loss-of-signal timing.
   localparam int CLK_MHZ        = 50;
   localparam int LOSS_TIME_US   = 20;
   localparam int LOSS_CYCLES    = LOSS_TIME_US * CLK_MHZ;
   localparam int CLEAR_WIN_US   = 20;
   localparam int CLEAR_CYCLES   = CLEAR_WIN_US * CLK_MHZ;
   localparam int CLEAR_MARKS    = 8;
   localparam int TIMER_W        = 11;
   localparam int MARK_W         = 4;
endpackage

//--- hdl/strap_level_sync.sv
// Three-level strap sampler: high, low and a mid/floating indication.
// Assumes the pad provides a weak-high and weak-low probe result as two pins.
`timescale 1ns/1ps
module strap_level_sync (
   input  wire logic                  i_clk,
   input  wire logic                  i_sys_rst,
   input  wire logic                  i_probe_up,
   input  wire logic                  i_probe_dn,
   output cfg_select_pkg::level_t     o_level
);
   // The pad reports the pin level with a pull-up probe and a pull-down probe.
   // Equal answers mean a driven pin, differing answers mean mid or floating.
   logic [2:0] up_ff;
   logic [2:0] dn_ff;
   cfg_select_pkg::level_t level_ff;
   cfg_select_pkg::level_t nxt_level;
   wire stable = (up_ff[2] == up_ff[1]) && (dn_ff[2] == dn_ff[1]);

   assign nxt_level = !stable ? level_ff :
                      (up_ff[2] && dn_ff[2]) ? cfg_select_pkg::LVL_HIGH :
                      (!up_ff[2] && !dn_ff[2]) ? cfg_select_pkg::LVL_LOW :
                      cfg_select_pkg::LVL_MID;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         up_ff    <= 3'h0;
         dn_ff    <= 3'h0;
         level_ff <= cfg_select_pkg::LVL_LOW;
      end else begin
         up_ff    <= {up_ff[1:0], i_probe_up};
         dn_ff    <= {dn_ff[1:0], i_probe_dn};
         level_ff <= nxt_level; // see [R20]
      end
   end

   assign o_level = level_ff;
endmodule // strap_level_sync

//--- bench/strap_board_model.sv
// Board side of the configuration block: straps, the multiplex pin and the monitor pins.
// Assumes the bench requests levels at the falling clock edge and the pads are probed twice.
`timescale 1ns/1ps
module strap_board_model (
   input  wire cfg_select_pkg::level_t i_mode_lvl,
   input  wire cfg_select_pkg::level_t i_atten_lvl,
   input  wire logic                   i_host_cs_n,
   input  wire logic                   i_mux_req,
   input  wire logic [4:0]             i_pins_req,
   output logic                        o_mode_probe_up,
   output logic                        o_mode_probe_dn,
   output logic                        o_atten_probe_up,
   output logic                        o_atten_probe_dn,
   output logic                        o_mux,
   output logic [4:0]                  o_pins
);
   logic                   hw_strap;
   cfg_select_pkg::level_t shared_lvl;

   // A mid-supply or floating pad follows the pull-up probe only, so it reads up=1 dn=0.
   assign o_mode_probe_up  = (i_mode_lvl != cfg_select_pkg::LVL_LOW);
   assign o_mode_probe_dn  = (i_mode_lvl == cfg_select_pkg::LVL_HIGH);
   assign hw_strap         = (i_mode_lvl == cfg_select_pkg::LVL_LOW);
   // In host mode the position pin is the host's chip select: high when idle, low for an access.
   assign shared_lvl       = hw_strap    ? i_atten_lvl :
                             i_host_cs_n ? cfg_select_pkg::LVL_HIGH :
                             cfg_select_pkg::LVL_LOW;
   assign o_atten_probe_up = (shared_lvl != cfg_select_pkg::LVL_LOW);
   assign o_atten_probe_dn = (shared_lvl == cfg_select_pkg::LVL_HIGH);
   // In hardware mode the board ties the unused multiplex pin and the monitor msb to ground.
   assign o_mux            = hw_strap ? 1'h0 : i_mux_req;
   assign o_pins           = {hw_strap ? 1'h0 : i_pins_req[4], i_pins_req[3:0]};
endmodule // strap_board_model

//--- bench/line_interface_config_select_bench.sv
// Self-checking bench for the configuration select block with a board strap model.
// Assumes short loss timing parameters so the loss flag scenarios stay brief.
`timescale 1ns/1ps
module line_interface_config_select_bench;
   localparam int LIMIT = 5000;
   logic                   i_clk = 1'h0;
   logic                   i_sys_rst;
   cfg_select_pkg::level_t mode_lvl, atten_lvl;
   logic                   code_pin, mux_req, sw_code, sw_dir, host_cs_n;
   logic [4:0]             pins_req;
   logic [2:0]             sw_ch;
   logic [7:0]             uni, loop, rx_mark;
   wire                    mode_up, mode_dn, atten_up, atten_dn, mux_w;
   wire  [4:0]             pins_w;
   logic [1:0]             o_op_mode, o_jitter_atten_position;
   logic [7:0]             o_line_code_ami, o_signal_loss_flag;
   logic                   o_host_bus_style_select, o_parallel_port_en, o_serial_port_en;
   logic                   o_bus_multiplexed, o_monitor_en, o_monitor_direction_select;
   logic                   o_monitor_unsupported;
   logic [4:0]             o_host_address;
   logic [2:0]             o_monitor_channel_code;
   int                     err_total = 0;
   int                     n_compared = 0;
   int                     cycles = 0;

   always #10 i_clk = ~i_clk;

   strap_board_model board (.i_mode_lvl(mode_lvl), .i_atten_lvl(atten_lvl),
      .i_host_cs_n(host_cs_n), .i_mux_req(mux_req),
      .i_pins_req(pins_req), .o_mode_probe_up(mode_up), .o_mode_probe_dn(mode_dn),
      .o_atten_probe_up(atten_up), .o_atten_probe_dn(atten_dn), .o_mux(mux_w),
      .o_pins(pins_w));

   line_interface_config_select #(.LOSS_CYCLES(16), .CLEAR_CYCLES(16), .CLEAR_MARKS(3)) dut (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_mode_probe_up(mode_up),
      .i_mode_probe_dn(mode_dn), .i_atten_probe_up(atten_up), .i_atten_probe_dn(atten_dn),
      .i_code_bus_pin(code_pin), .i_bus_multiplex_select(mux_w), .i_monitor_pins(pins_w),
      .i_unipolar_bipolar_select(uni), .i_sw_line_code_select(sw_code),
      .i_sw_monitor_direction_select(sw_dir), .i_sw_monitor_channel_code(sw_ch),
      .i_analog_loopback(loop), .i_rx_mark(rx_mark), .o_op_mode(o_op_mode),
      .o_line_code_ami(o_line_code_ami), .o_host_bus_style_select(o_host_bus_style_select),
      .o_jitter_atten_position(o_jitter_atten_position),
      .o_parallel_port_en(o_parallel_port_en), .o_serial_port_en(o_serial_port_en),
      .o_bus_multiplexed(o_bus_multiplexed), .o_host_address(o_host_address),
      .o_monitor_en(o_monitor_en), .o_monitor_direction_select(o_monitor_direction_select),
      .o_monitor_channel_code(o_monitor_channel_code),
      .o_monitor_unsupported(o_monitor_unsupported), .o_signal_loss_flag(o_signal_loss_flag));

   function automatic cfg_select_pkg::level_t lvl_of(input int k);
      case (k)
         0: return cfg_select_pkg::LVL_LOW;
         1: return cfg_select_pkg::LVL_HIGH;
         default: return cfg_select_pkg::LVL_MID;
      endcase
   endfunction

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic mark_for(input logic [7:0] val, input int n);
      repeat (n) begin
         @(negedge i_clk);
         rx_mark = val;
      end
   endtask

   // Expectations come from the strap levels and the pins as the board presents them.
   task automatic check_cfg();
      logic       hw, par, en, dir;
      logic [2:0] code;
      logic [1:0] md, atten;
      logic [7:0] ami;
      logic [4:0] addr;
      hw    = (mode_lvl == cfg_select_pkg::LVL_LOW);
      par   = (mode_lvl == cfg_select_pkg::LVL_HIGH);
      md    = hw ? 2'h0 : (par ? 2'h1 : 2'h3);
      ami   = hw ? (uni & {8{code_pin}}) : {8{sw_code}};
      atten = !hw ? cfg_select_pkg::ATTEN_OFF : (atten_lvl == cfg_select_pkg::LVL_LOW) ?
              cfg_select_pkg::ATTEN_TX : (atten_lvl == cfg_select_pkg::LVL_HIGH) ?
              cfg_select_pkg::ATTEN_RX : cfg_select_pkg::ATTEN_OFF;
      code  = hw ? pins_w[2:0] : sw_ch;
      dir   = hw ? pins_w[3] : sw_dir;
      en    = (code != 3'h0);
      addr  = (!hw && !(par && mux_w)) ? pins_w : 5'h00;
      chk({6'h0, o_op_mode}, {6'h0, md});
      chk(o_line_code_ami, ami);
      chk({7'h0, o_host_bus_style_select}, {7'h0, !hw & code_pin});
      chk({6'h0, o_jitter_atten_position}, {6'h0, atten});
      chk({6'h0, o_parallel_port_en, o_serial_port_en}, {6'h0, par, !hw & !par});
      chk({7'h0, o_bus_multiplexed}, {7'h0, par & mux_w});
      chk({3'h0, o_host_address}, {3'h0, addr});
      chk({3'h0, o_monitor_en, o_monitor_direction_select, o_monitor_channel_code},
          {3'h0, en, en & dir, code});
      chk({7'h0, o_monitor_unsupported}, {7'h0, en & dir & loop[code]});
      chk(o_signal_loss_flag, 8'h00);
   endtask

   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         err_total++;
         close_out();
      end
   end

   initial begin
      i_sys_rst = 1'h1;
      mode_lvl  = cfg_select_pkg::LVL_HIGH;
      atten_lvl = cfg_select_pkg::LVL_LOW;
      {code_pin, mux_req, sw_code, sw_dir, host_cs_n} = 5'h1f;
      pins_req  = 5'h1f;
      sw_ch     = 3'h7;
      {uni, loop, rx_mark} = {8'hff, 8'hff, 8'hff};
      void'($urandom(32'h4d5a));
      repeat (6) @(negedge i_clk);
      chk({6'h0, o_op_mode}, 8'h00);
      chk(o_line_code_ami, 8'h00);
      i_sys_rst = 1'h0;
      // The first nine passes walk every mode against every attenuator level.
      for (int i = 0; i < 40; i++) begin
         @(negedge i_clk);
         if (i < 9) begin
            mode_lvl  = lvl_of(i / 3);
            atten_lvl = lvl_of(i % 3);
            pins_req  = i[0] ? 5'h1f : 5'h10;
            sw_ch     = i[0] ? 3'h7 : 3'h0;
            {code_pin, sw_code, sw_dir, mux_req} = {i[1], i[1], 1'h1, i[2]};
            host_cs_n = i[0];
            loop      = 8'h80;
            uni       = 8'h5a;
         end else begin
            mode_lvl  = lvl_of($urandom_range(2));
            atten_lvl = lvl_of($urandom_range(2));
            pins_req  = 5'($urandom);
            sw_ch     = 3'($urandom);
            {code_pin, sw_code, sw_dir, mux_req, host_cs_n} = 5'($urandom);
            loop      = 8'($urandom);
            uni       = 8'($urandom);
         end
         repeat (10) @(negedge i_clk);
         check_cfg();
      end
      // Channel 0 keeps marking; the others fall silent, then channel 2 recovers.
      // Flags rise 16 cycles into the silence; the three marks of channel 2 then fall early
      // in its first clearing window, while channel 1 gets only two before the window ends.
      mark_for(8'h01, 20);
      chk(o_signal_loss_flag, 8'hfe);
      mark_for(8'h07, 2);
      mark_for(8'h05, 1);
      mark_for(8'h01, 4);
      chk(o_signal_loss_flag, 8'hfa);
      mark_for(8'h01, 24);
      mark_for(8'h03, 1);
      mark_for(8'h01, 4);
      chk(o_signal_loss_flag, 8'hfe);
      close_out();
   end
endmodule // line_interface_config_select_bench
